// ==== src/byte_store.sv ====
`timescale 1ns/1ps
module byte_store #(
  parameter int DEPTH = 256,
  parameter int AW    = 8
) (
  // Clock and reset
  input  wire logic          core_clk_i,
  input  wire logic          rst_b_i,
  // Write port
  input  wire logic          wr_en_i,
  input  wire logic [AW-1:0] wr_idx_i,
  input  wire logic [7:0]    wr_data_i,
  // Read port
  input  wire logic [AW-1:0] rd_idx_i,
  output logic      [7:0]    rd_data_o
);
  logic [7:0] mem_q [DEPTH];

  for (genvar i = 0; i < DEPTH; i++) begin : g_cell
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        mem_q[i] <= 8'h00;
      end else if (wr_en_i && wr_idx_i == AW'(i)) begin
        mem_q[i] <= wr_data_i;
      end
    end
  end

  // Indices past the end read as zero
  assign rd_data_o = (32'(rd_idx_i) < DEPTH) ? mem_q[rd_idx_i] : 8'h00;
endmodule // byte_store

// ==== src/host_cmd_consts.svh ====
`ifndef HOST_CMD_CONSTS_SVH
`define HOST_CMD_CONSTS_SVH

// Command codes
`define CMD_RD_REG     8'h04
`define CMD_RD_MULTI   8'h05
`define CMD_EE_WR      8'h06
`define CMD_EE_RD      8'h07
`define CMD_TX_FILL    8'h08
`define CMD_TX_SEND    8'h09

// Parameter limits
`define REG_LIST_MAX   9'h012
`define EE_ADDR_MAX    8'hFE
`define EE_END         9'h0FF
`define EE_WR_MAX      9'h0FF
`define TX_LEN_MAX     9'h104
`define LAST_BITS_MAX  8'h07
`define FULL_BYTE_BITS 4'h8

// Storage depths
`define EE_DEPTH       255
`define TX_DEPTH       260

`endif

// ==== src/host_cmd_dev.sv ====
`timescale 1ns/1ps
`include "host_cmd_consts.svh"
// Overview of operation
// RULE1: Command 0x04 returns one register, four bytes
// RULE2: Unknown register address raises an exception
// RULE3: Command 0x05 takes addresses in any order
// RULE4: Response holds only values, in request order
// RULE5: Multiple read needs one to eighteen addresses
// RULE6: Command 0x06 stores bytes at ascending addresses
// RULE7: Write start 0-254, count 1-255, else exception
// RULE8: Command 0x07 returns bytes in ascending order
// RULE9: Read start and end within 0-254
// RULE10: Command 0x08 fills transmit buffer, no start
// RULE11: Fill 1-260 bytes, never during transmission
// RULE12: Command 0x09 loads buffer then starts transmission
// RULE13: Valid bits 0 means eight, 1-7 literal
// RULE14: Host sets transceiver command before sending
// RULE15: Send completes once started, not when finished
// RULE16: Register bytes go out least significant first
// RULE17: Frame is code, parameters, then response phase
module host_cmd_dev
  import host_cmd_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_b_i,
  // Host port
  host_port_if.dev         hp,
  // Configuration register lookup
  output logic [7:0]       reg_addr_o,
  input  wire logic [31:0] reg_data_i,
  input  wire logic        reg_exists_i,
  // RF transmitter
  input  wire logic        tx_active_i,
  output logic             tx_start_o,
  output logic [8:0]       tx_len_o,
  output logic [3:0]       tx_last_bits_o,
  input  wire logic [8:0]  tx_rd_idx_i,
  output logic [7:0]       tx_rd_data_o
);
  function automatic logic is_reg_read(input byte_t code);
    return code == `CMD_RD_REG || code == `CMD_RD_MULTI;
  endfunction

  dev_state_t state_q;
  byte_t      code_q;
  logic [8:0] cnt_q;
  byte_t      start_q;
  byte_t      len_q;
  logic [2:0] bits_q;
  logic       err_q;
  logic       busy_q;
  byte_t      addr_q [18];
  word_t      word_q [18];
  logic [4:0] n_addr_q;
  logic [4:0] ex_idx_q;
  logic       ex_phase_q;
  logic [8:0] rsp_idx_q;
  logic       rsp_valid_q;
  byte_t      rsp_byte_q;

  logic       acc;
  logic       first;
  logic       last;
  byte_t      code_in;
  logic [8:0] pc;
  logic [8:0] ee_sum;
  logic       byte_err;
  logic       end_err;
  logic       ee_we;
  logic       tx_we;
  logic [8:0] tx_widx;
  logic       go_exec;
  logic       ex_done;
  byte_t      ee_rd;
  byte_t      tx_rd;
  byte_t      rsp_d;

  assign acc     = hp.cmd_valid & ~busy_q;
  assign first   = state_q == ST_IDLE;
  assign last    = acc & hp.cmd_last;
  assign code_in = first ? hp.cmd_byte : code_q;
  assign pc      = first ? 9'h000 : cnt_q + 9'h001;
  assign ee_sum  = {1'h0, start_q} + cnt_q - 9'h001;
  assign ex_done = ex_phase_q && ex_idx_q == n_addr_q - 5'h01;

  // Per-byte parameter checks and storage strobes
  always_comb begin
    byte_err = 1'h0;
    ee_we    = 1'h0;
    tx_we    = 1'h0;
    tx_widx  = cnt_q;
    unique case (code_q)
      `CMD_RD_REG:   byte_err = cnt_q != 9'h000;
      `CMD_RD_MULTI: byte_err = cnt_q >= `REG_LIST_MAX; // RULE5
      `CMD_EE_WR: begin
        if (cnt_q == 9'h000) begin
          byte_err = hp.cmd_byte > `EE_ADDR_MAX; // RULE7
        end else begin
          byte_err = cnt_q > `EE_WR_MAX || ee_sum > {1'h0, `EE_ADDR_MAX}; // RULE7
          ee_we    = 1'h1;
        end
      end
      `CMD_EE_RD: begin
        if (cnt_q == 9'h000) begin
          byte_err = hp.cmd_byte > `EE_ADDR_MAX; // RULE9
        end else begin
          byte_err = cnt_q > 9'h001;
        end
      end
      `CMD_TX_FILL: begin
        byte_err = cnt_q >= `TX_LEN_MAX || tx_active_i; // RULE11
        tx_we    = 1'h1;
      end
      `CMD_TX_SEND: begin
        if (cnt_q == 9'h000) begin
          byte_err = hp.cmd_byte > `LAST_BITS_MAX;
        end else begin
          byte_err = cnt_q > `TX_LEN_MAX || tx_active_i;
          tx_we    = 1'h1;
          tx_widx  = cnt_q - 9'h001;
        end
      end
      default: byte_err = 1'h1;
    endcase
  end

  // Whole-frame checks on the last byte
  always_comb begin
    unique case (code_in)
      `CMD_RD_REG:   end_err = pc != 9'h001;
      `CMD_RD_MULTI: end_err = pc == 9'h000; // RULE5
      `CMD_EE_WR:    end_err = pc < 9'h002; // RULE7
      `CMD_EE_RD:    end_err = pc != 9'h002 ||
                               {1'h0, start_q} + {1'h0, hp.cmd_byte} > `EE_END; // RULE9
      `CMD_TX_FILL:  end_err = pc == 9'h000; // RULE11
      `CMD_TX_SEND:  end_err = pc == 9'h000;
      default:       end_err = 1'h1;
    endcase
  end

  assign go_exec = last && !first && is_reg_read(code_q) && !err_q && !byte_err && !end_err;

  // Frame sequencing
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= ST_IDLE;
      code_q  <= 8'h00;
      cnt_q   <= 9'h000;
    end else begin
      unique case (state_q)
        ST_IDLE: if (acc) begin // RULE17
          code_q  <= hp.cmd_byte;
          cnt_q   <= 9'h000;
          state_q <= hp.cmd_last ? ST_IDLE : ST_RECV;
        end
        ST_RECV: if (acc) begin
          if (cnt_q != 9'h1FF) begin
            cnt_q <= cnt_q + 9'h001;
          end
          if (hp.cmd_last) begin
            state_q <= go_exec ? ST_EXEC : ST_IDLE;
          end
        end
        ST_EXEC: if (ex_done) begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Exception flag, cleared only by the next frame
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      err_q <= 1'h0;
    end else if (acc && first) begin
      err_q <= hp.cmd_last & end_err;
    end else if (acc) begin
      err_q <= err_q | byte_err | (hp.cmd_last & end_err);
    end else if (state_q == ST_EXEC && ex_phase_q && !reg_exists_i) begin
      err_q <= 1'h1; // RULE2
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      busy_q <= 1'h0;
    end else if (go_exec) begin
      busy_q <= 1'h1;
    end else if (ex_done) begin
      busy_q <= 1'h0;
    end
  end

  // Parameter capture
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      start_q  <= 8'h00;
      len_q    <= 8'h00;
      bits_q   <= 3'h0;
      n_addr_q <= 5'h00;
      for (int i = 0; i < 18; i++) begin
        addr_q[i] <= 8'h00;
      end
    end else if (acc && !first) begin
      if (is_reg_read(code_q) && cnt_q < `REG_LIST_MAX) begin
        addr_q[cnt_q[4:0]] <= hp.cmd_byte; // RULE3
        n_addr_q           <= pc[4:0];
      end
      if (cnt_q == 9'h000) begin
        start_q <= hp.cmd_byte;
        bits_q  <= hp.cmd_byte[2:0];
      end
      if (cnt_q == 9'h001) begin
        len_q <= hp.cmd_byte;
      end
    end
  end

  // Register fetch: address out, value in on the following cycle
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ex_idx_q   <= 5'h00;
      ex_phase_q <= 1'h0;
      reg_addr_o <= 8'h00;
      for (int i = 0; i < 18; i++) begin
        word_q[i] <= 32'h0000_0000;
      end
    end else if (state_q == ST_EXEC) begin
      ex_phase_q <= ~ex_phase_q;
      if (!ex_phase_q) begin
        reg_addr_o <= addr_q[ex_idx_q]; // RULE1
      end else begin
        word_q[ex_idx_q] <= reg_data_i; // RULE4
        ex_idx_q         <= ex_idx_q + 5'h01;
      end
    end else begin
      ex_idx_q   <= 5'h00;
      ex_phase_q <= 1'h0;
    end
  end

  byte_store #(
    .DEPTH (`EE_DEPTH),
    .AW    (8)
  ) u_ee (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .wr_en_i    (acc && !first && ee_we && !byte_err && !err_q), // RULE6
    .wr_idx_i   (ee_sum[7:0]),
    .wr_data_i  (hp.cmd_byte),
    .rd_idx_i   (start_q + rsp_idx_q[7:0]), // RULE8
    .rd_data_o  (ee_rd)
  );

  byte_store #(
    .DEPTH (`TX_DEPTH),
    .AW    (9)
  ) u_tx (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .wr_en_i    (acc && !first && tx_we && !byte_err && !err_q), // RULE10
    .wr_idx_i   (tx_widx),
    .wr_data_i  (hp.cmd_byte),
    .rd_idx_i   (tx_rd_idx_i),
    .rd_data_o  (tx_rd)
  );

  // Transmitter hand-off: start pulses only for the send command
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_start_o     <= 1'h0;
      tx_len_o       <= 9'h000;
      tx_last_bits_o <= `FULL_BYTE_BITS;
      tx_rd_data_o   <= 8'h00;
    end else begin
      tx_rd_data_o <= tx_rd;
      tx_start_o   <= 1'h0;
      if (last && !first && !err_q && !byte_err && !end_err) begin
        if (code_q == `CMD_TX_FILL) begin
          tx_len_o <= pc; // RULE10
        end
        if (code_q == `CMD_TX_SEND) begin
          tx_start_o <= 1'h1; // RULE12 RULE15
          tx_len_o   <= cnt_q;
          if (cnt_q == 9'h000) begin
            tx_last_bits_o <= hp.cmd_byte[2:0] == 3'h0 ? `FULL_BYTE_BITS
                                                       : {1'h0, hp.cmd_byte[2:0]}; // RULE13
          end else begin
            tx_last_bits_o <= bits_q == 3'h0 ? `FULL_BYTE_BITS : {1'h0, bits_q}; // RULE13
          end
        end
      end
    end
  end

  // Response byte selection
  always_comb begin
    rsp_d = 8'h00;
    if (!err_q) begin
      if (is_reg_read(code_q) && rsp_idx_q < {2'h0, n_addr_q, 2'h0}) begin
        rsp_d = word_q[rsp_idx_q[6:2]][8*rsp_idx_q[1:0] +: 8]; // RULE16 RULE4
      end else if (code_q == `CMD_EE_RD && rsp_idx_q < {1'h0, len_q}) begin
        rsp_d = ee_rd; // RULE8
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rsp_idx_q   <= 9'h000;
      rsp_valid_q <= 1'h0;
      rsp_byte_q  <= 8'h00;
    end else begin
      rsp_valid_q <= 1'h0;
      if (acc && first) begin
        rsp_idx_q <= 9'h000;
      end else if (hp.rsp_req && state_q == ST_IDLE && !busy_q) begin
        rsp_valid_q <= 1'h1; // RULE17
        rsp_byte_q  <= rsp_d;
        if (rsp_idx_q != 9'h1FF) begin
          rsp_idx_q <= rsp_idx_q + 9'h001;
        end
      end
    end
  end

  assign hp.rsp_valid = rsp_valid_q;
  assign hp.rsp_byte  = rsp_byte_q;
  assign hp.busy      = busy_q;
  assign hp.exc       = err_q;
endmodule // host_cmd_dev

// ==== src/host_cmd_host.sv ====
`timescale 1ns/1ps
`include "host_cmd_consts.svh"
module host_cmd_host
  import host_cmd_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rst_b_i,
  // Host port
  host_port_if.host       hp,
  // Command bytes from the user
  input  wire logic       usr_valid_i,
  input  wire logic [7:0] usr_byte_i,
  input  wire logic       usr_last_i,
  output logic            usr_ready_o,
  // Response reads
  input  wire logic       usr_rd_req_i,
  output logic            usr_rd_valid_o,
  output logic [7:0]      usr_rd_byte_o,
  // Status
  output logic            usr_busy_o,
  output logic            usr_exc_o,
  output logic            usr_bad_o
);
  host_state_t state_q;
  byte_t       code_q;
  logic [8:0]  cnt_q;
  byte_t       p0_q;
  logic        cmd_valid_q;
  byte_t       cmd_byte_q;
  logic        cmd_last_q;
  logic        rsp_req_q;

  logic        take;
  logic [8:0]  pc;
  logic        bad;

  assign take = usr_valid_i & usr_ready_o;
  assign pc   = state_q == H_IDLE ? 9'h000 : cnt_q + 9'h001;

  // Host-side limits checked on the frame's last byte
  always_comb begin
    unique case (state_q == H_IDLE ? usr_byte_i : code_q)
      `CMD_RD_REG:   bad = pc != 9'h001;
      `CMD_RD_MULTI: bad = pc == 9'h000 || pc > `REG_LIST_MAX; // RULE5
      `CMD_EE_WR:    bad = pc < 9'h002 || pc > `EE_WR_MAX + 9'h001 ||
                           p0_q > `EE_ADDR_MAX; // RULE7
      `CMD_EE_RD:    bad = pc != 9'h002 || p0_q > `EE_ADDR_MAX ||
                           {1'h0, p0_q} + {1'h0, usr_byte_i} > `EE_END; // RULE9
      `CMD_TX_FILL:  bad = pc == 9'h000 || pc > `TX_LEN_MAX; // RULE11
      `CMD_TX_SEND:  bad = pc == 9'h000 || pc > `TX_LEN_MAX + 9'h001;
      default:       bad = 1'h1;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= H_IDLE;
      code_q  <= 8'h00;
      cnt_q   <= 9'h000;
      p0_q    <= 8'h00;
    end else begin
      unique case (state_q)
        H_IDLE: if (take) begin // RULE17
          code_q  <= usr_byte_i;
          cnt_q   <= 9'h000;
          state_q <= usr_last_i ? H_WAIT : H_FRAME;
        end
        H_FRAME: if (take) begin
          if (cnt_q == 9'h000) begin
            p0_q <= usr_byte_i;
          end
          if (cnt_q != 9'h1FF) begin
            cnt_q <= cnt_q + 9'h001;
          end
          if (usr_last_i) begin
            state_q <= H_WAIT;
          end
        end
        H_WAIT: if (!cmd_valid_q && !hp.busy) begin
          state_q <= H_IDLE;
        end
      endcase
    end
  end

  // Ready drops after each last byte until the device has settled
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      usr_ready_o <= 1'h0;
    end else begin
      usr_ready_o <= state_q != H_WAIT && !(take && usr_last_i) && !hp.busy;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cmd_valid_q <= 1'h0;
      cmd_byte_q  <= 8'h00;
      cmd_last_q  <= 1'h0;
    end else begin
      cmd_valid_q <= take;
      if (take) begin
        cmd_byte_q <= usr_byte_i;
        cmd_last_q <= usr_last_i;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      usr_bad_o <= 1'h0;
    end else if (take && usr_last_i) begin
      usr_bad_o <= bad;
    end
  end

  // Response reads only between frames
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rsp_req_q      <= 1'h0;
      usr_rd_valid_o <= 1'h0;
      usr_rd_byte_o  <= 8'h00;
      usr_busy_o     <= 1'h0;
      usr_exc_o      <= 1'h0;
    end else begin
      rsp_req_q      <= usr_rd_req_i && state_q == H_IDLE && !hp.busy; // RULE17
      usr_rd_valid_o <= hp.rsp_valid;
      usr_rd_byte_o  <= hp.rsp_byte;
      usr_busy_o     <= hp.busy;
      usr_exc_o      <= hp.exc;
    end
  end

  assign hp.cmd_valid = cmd_valid_q;
  assign hp.cmd_byte  = cmd_byte_q;
  assign hp.cmd_last  = cmd_last_q;
  assign hp.rsp_req   = rsp_req_q;
endmodule // host_cmd_host

// ==== src/host_cmd_pkg.sv ====
package host_cmd_pkg;

  typedef logic [7:0]  byte_t;
  typedef logic [31:0] word_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RECV = 3'b010,
    ST_EXEC = 3'b100
  } dev_state_t;

  typedef enum logic [2:0] {
    H_IDLE  = 3'b001,
    H_FRAME = 3'b010,
    H_WAIT  = 3'b100
  } host_state_t;

endpackage

// ==== src/host_port_if.sv ====
`timescale 1ns/1ps
interface host_port_if;
  logic       cmd_valid;
  logic [7:0] cmd_byte;
  logic       cmd_last;
  logic       rsp_req;
  logic       rsp_valid;
  logic [7:0] rsp_byte;
  logic       busy;
  logic       exc;

  modport dev (
    input  cmd_valid, cmd_byte, cmd_last, rsp_req,
    output rsp_valid, rsp_byte, busy, exc
  );

  modport host (
    output cmd_valid, cmd_byte, cmd_last, rsp_req,
    input  rsp_valid, rsp_byte, busy, exc
  );
endinterface

// ==== verif/host_cmd_reg_eeprom_txbuf_chk.sv ====
`timescale 1ns/1ps
`include "host_cmd_consts.svh"
module host_cmd_reg_eeprom_txbuf_chk (
  // Clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rst_b_i,
  // Host port
  input  wire logic       cmd_valid,
  input  wire logic [7:0] cmd_byte,
  input  wire logic       cmd_last,
  input  wire logic       rsp_req,
  input  wire logic       rsp_valid,
  input  wire logic [7:0] rsp_byte,
  input  wire logic       busy,
  input  wire logic       exc
);
  logic       take;
  logic       first_q;
  logic [7:0] code_q;
  logic [7:0] start_q;
  logic [8:0] cnt_q;

  // Frame tracking: code, parameter count, first parameter
  assign take = cmd_valid && !busy;

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) first_q <= 1'b1;
    else if (take) first_q <= cmd_last;
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) code_q <= 8'h00;
    else if (take && first_q) code_q <= cmd_byte;
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) cnt_q <= 9'h000;
    else if (take && first_q) cnt_q <= 9'h000;
    else if (take && cnt_q != 9'h1FF) cnt_q <= cnt_q + 9'h001;
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) start_q <= 8'h00;
    else if (take && !first_q && cnt_q == 9'h000) start_q <= cmd_byte;
  end

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  a_rsp_needs_req: assert property (rsp_valid |-> $past(rsp_req) && !$past(busy))
    else $error("response byte without a request");
  a_rsp_zero_exc: assert property (rsp_valid && exc |-> rsp_byte == 8'h00)
    else $error("response data after an exception");
  a_exc_stands: assert property ($fell(exc) |-> $past(take && first_q))
    else $error("exception dropped before the next frame");
  a_busy_cause: assert property ($rose(busy) |->
    $past(take && cmd_last && (code_q == `CMD_RD_REG || code_q == `CMD_RD_MULTI)))
    else $error("busy without a register read frame");
  a_rd_reg_busy: assert property (take && cmd_last && !first_q
    && code_q == `CMD_RD_REG && cnt_q == 9'h000 |=> busy ##1 busy)
    else $error("register fetch not started");
  a_code_bad: assert property (take && !first_q
    && (code_q < `CMD_RD_REG || code_q > `CMD_TX_SEND) |=> exc)
    else $error("unknown code accepted");
  a_code_only: assert property (take && first_q && cmd_last |=> exc)
    else $error("frame without parameters accepted");
  a_list_max: assert property (take && !first_q && code_q == `CMD_RD_MULTI
    && cnt_q == 9'h012 |=> exc)
    else $error("address list too long accepted");
  a_ee_wr_start: assert property (take && !first_q && code_q == `CMD_EE_WR
    && cnt_q == 9'h000 && cmd_byte > `EE_ADDR_MAX |=> exc)
    else $error("write start out of range accepted");
  a_ee_wr_end: assert property (take && !first_q && code_q == `CMD_EE_WR
    && cnt_q != 9'h000 && {2'b00, start_q} + {1'b0, cnt_q} > 10'h0FF |=> exc)
    else $error("write past the last address accepted");
  a_ee_rd_end: assert property (take && !first_q && code_q == `CMD_EE_RD
    && cnt_q == 9'h001 && {1'b0, start_q} + {1'b0, cmd_byte} > 9'h0FF |=> exc)
    else $error("read past the last address accepted");
  a_tx_len_max: assert property (take && !first_q && ((code_q == `CMD_TX_FILL
    && cnt_q == 9'h104) || (code_q == `CMD_TX_SEND && cnt_q == 9'h105)) |=> exc)
    else $error("transmit payload too long accepted");
  a_tx_bits: assert property (take && !first_q && code_q == `CMD_TX_SEND
    && cnt_q == 9'h000 && cmd_byte > `LAST_BITS_MAX |=> exc)
    else $error("valid bit count out of range accepted");

  c_multi: cover property (take && first_q && cmd_byte == `CMD_RD_MULTI);
  c_fetch: cover property ($rose(busy));
  c_rsp: cover property (rsp_valid && !exc);
  c_exc: cover property ($rose(exc));
endmodule // host_cmd_reg_eeprom_txbuf_chk

// ==== verif/tb_host_cmd_reg_eeprom_txbuf.sv ====
`timescale 1ns/1ps
`include "host_cmd_consts.svh"
module tb_host_cmd_reg_eeprom_txbuf
  import host_cmd_pkg::*;
;
  logic       core_clk_i;
  logic       rst_b_i;
  logic       usr_valid_i;
  byte_t      usr_byte_i;
  logic       usr_last_i;
  logic       usr_ready_o;
  logic       usr_rd_req_i;
  logic       usr_rd_valid_o;
  byte_t      usr_rd_byte_o;
  logic       usr_busy_o;
  logic       usr_exc_o;
  logic       usr_bad_o;
  byte_t      reg_addr_o;
  word_t      reg_data_i;
  logic       reg_exists_i;
  logic       tx_active_i;
  logic       tx_start_o;
  logic [8:0] tx_len_o;
  logic [3:0] tx_last_bits_o;
  logic [8:0] tx_rd_idx_i;
  byte_t      tx_rd_data_o;
  int         error_cnt = 0;
  int         comparisons = 0;
  int         starts = 0;
  int         tx_left = 0;

  host_port_if host_port_if_i ();

  host_cmd_host host_cmd_host_i (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
    .hp(host_port_if_i.host), .usr_valid_i(usr_valid_i), .usr_byte_i(usr_byte_i),
    .usr_last_i(usr_last_i), .usr_ready_o(usr_ready_o), .usr_rd_req_i(usr_rd_req_i),
    .usr_rd_valid_o(usr_rd_valid_o), .usr_rd_byte_o(usr_rd_byte_o),
    .usr_busy_o(usr_busy_o), .usr_exc_o(usr_exc_o), .usr_bad_o(usr_bad_o));

  host_cmd_dev host_cmd_dev_i (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
    .hp(host_port_if_i.dev), .reg_addr_o(reg_addr_o), .reg_data_i(reg_data_i),
    .reg_exists_i(reg_exists_i), .tx_active_i(tx_active_i), .tx_start_o(tx_start_o),
    .tx_len_o(tx_len_o), .tx_last_bits_o(tx_last_bits_o), .tx_rd_idx_i(tx_rd_idx_i),
    .tx_rd_data_o(tx_rd_data_o));

  host_cmd_reg_eeprom_txbuf_chk host_cmd_reg_eeprom_txbuf_chk_i (.core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i), .cmd_valid(host_port_if_i.cmd_valid),
    .cmd_byte(host_port_if_i.cmd_byte), .cmd_last(host_port_if_i.cmd_last),
    .rsp_req(host_port_if_i.rsp_req), .rsp_valid(host_port_if_i.rsp_valid),
    .rsp_byte(host_port_if_i.rsp_byte), .busy(host_port_if_i.busy),
    .exc(host_port_if_i.exc));

  initial begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end

  // Registers below 0x40 exist; values differ in every byte lane
  function automatic word_t reg_val(input byte_t a);
    return {a ^ 8'hA5, ~a, a, a + 8'h3C};
  endfunction
  assign reg_exists_i = (reg_addr_o < 8'h40);
  assign reg_data_i   = reg_val(reg_addr_o);

  // Transmission stays active for 40 cycles after each start pulse
  always @(posedge core_clk_i) begin
    if (tx_start_o === 1'b1) begin
      starts  <= starts + 1;
      tx_left <= 40;
    end else if (tx_left != 0) begin
      tx_left <= tx_left - 1;
    end
  end
  assign tx_active_i = (tx_left != 0);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("Comparisons %0d, errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Sends one frame, waits until both ends are idle, checks the exception flag
  task automatic frame(input byte_t f[$], input logic exp_exc);
    int n;
    foreach (f[i]) begin
      usr_valid_i <= 1'b1;
      usr_byte_i  <= f[i];
      usr_last_i  <= (i == f.size() - 1);
      n = 0;
      do begin
        @(posedge core_clk_i);
        n++;
      end while (usr_ready_o !== 1'b1 && n < 50);
      chk(usr_ready_o, 1'b1, "byte accepted");
    end
    usr_valid_i <= 1'b0;
    usr_last_i  <= 1'b0;
    n = 0;
    repeat (4) @(posedge core_clk_i);
    while (!(usr_ready_o === 1'b1 && usr_busy_o === 1'b0 && host_port_if_i.busy === 1'b0)
           && n < 200) begin
      n++;
      @(posedge core_clk_i);
    end
    chk(usr_ready_o, 1'b1, "frame settled");
    repeat (2) @(posedge core_clk_i);
    chk(usr_exc_o, exp_exc, "exception flag");
  endtask

  task automatic get(input int cnt, output byte_t r[$]);
    int w;
    r = {};
    repeat (cnt) begin
      usr_rd_req_i <= 1'b1;
      @(posedge core_clk_i);
      usr_rd_req_i <= 1'b0;
      w = 0;
      do begin
        @(posedge core_clk_i);
        w++;
      end while (usr_rd_valid_o !== 1'b1 && w < 10);
      chk(usr_rd_valid_o, 1'b1, "response strobe");
      r.push_back(usr_rd_byte_o);
    end
  endtask

  task automatic buf_chk(input int idx, input byte_t exp);
    tx_rd_idx_i <= idx[8:0];
    repeat (2) @(posedge core_clk_i);
    chk(tx_rd_data_o, exp, "transmit buffer");
  endtask

  initial begin
    repeat (20000) @(posedge core_clk_i);
    error_cnt++;
    $display("Error at %0t: watchdog expired", $time);
    end_sim();
  end

  initial begin
    byte_t f[$];
    byte_t r[$];
    int    k;
    usr_valid_i  = 1'b0;
    usr_byte_i   = 8'h00;
    usr_last_i   = 1'b0;
    usr_rd_req_i = 1'b0;
    tx_rd_idx_i  = 9'h000;
    rst_b_i      = 1'b0;
    repeat (8) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    frame('{`CMD_RD_REG, 8'h12}, 1'b0);
    chk(usr_bad_o, 1'b0, "host limit check");
    get(4, r);
    chk({r[3], r[2], r[1], r[0]}, reg_val(8'h12), "single register");
    frame('{`CMD_RD_REG, 8'h50}, 1'b1);
    f = {`CMD_RD_MULTI};
    for (k = 0; k < 18; k++) f.push_back(byte_t'((k * 7) % 64));
    frame(f, 1'b0);
    get(72, r);
    for (k = 0; k < 18; k++)
      chk({r[4*k+3], r[4*k+2], r[4*k+1], r[4*k]}, reg_val(f[k+1]), "reg list");
    f.push_back(8'h01);
    frame(f, 1'b1);
    frame('{`CMD_RD_MULTI}, 1'b1);
    chk(usr_bad_o, 1'b1, "host limit check");
    frame('{`CMD_RD_MULTI, 8'h02, 8'h50}, 1'b1);
    frame('{`CMD_EE_WR, 8'hFC, 8'hA1, 8'hB2, 8'hC3}, 1'b0);
    frame('{`CMD_EE_RD, 8'hFC, 8'h03}, 1'b0);
    get(3, r);
    for (k = 0; k < 3; k++) chk(r[k], 8'hA1 + 8'h11 * k, "eeprom data");
    frame('{`CMD_EE_WR, 8'hFF, 8'h00}, 1'b1);
    frame('{`CMD_EE_WR, 8'h10}, 1'b1);
    frame('{`CMD_EE_RD, 8'hFD, 8'h03}, 1'b1);
    chk(usr_bad_o, 1'b1, "host read limit");
    frame('{`CMD_EE_RD, 8'hFF, 8'h00}, 1'b1);
    f = {`CMD_EE_WR, 8'h00};
    for (k = 0; k < 255; k++) f.push_back(byte_t'(k ^ 8'h5A));
    frame(f, 1'b0);
    frame('{`CMD_EE_RD, 8'h00, 8'hFF}, 1'b0);
    get(255, r);
    for (k = 0; k < 255; k++) chk(r[k], byte_t'(k ^ 8'h5A), "eeprom block");
    f.push_back(8'h00);
    frame(f, 1'b1);
    f = {`CMD_TX_FILL};
    for (k = 0; k < 260; k++) f.push_back(byte_t'(k ^ 8'h3C));
    frame(f, 1'b0);
    chk(tx_len_o, 9'h104, "fill length");
    chk(starts, 0, "no start on fill");
    buf_chk(0, 8'h3C);
    buf_chk(259, byte_t'(259 ^ 8'h3C));
    f.push_back(8'h00);
    frame(f, 1'b1);
    for (k = 0; k < 8; k++) begin
      while (tx_active_i === 1'b1) @(posedge core_clk_i);
      frame('{`CMD_TX_SEND, byte_t'(k), 8'hE0, byte_t'(8'hE1 + k)}, 1'b0);
      chk(tx_active_i, 1'b1, "send returns during transmission");
      chk(starts, k + 1, "start pulses");
      chk(tx_len_o, 9'h002, "send length");
      chk(tx_last_bits_o, (k == 0) ? 8 : k, "last byte bits");
      buf_chk(1, byte_t'(8'hE1 + k));
    end
    frame('{`CMD_TX_FILL, 8'h55}, 1'b1);
    while (tx_active_i === 1'b1) @(posedge core_clk_i);
    frame('{`CMD_TX_SEND, 8'h08, 8'hE0}, 1'b1);
    frame('{8'h0A, 8'h00}, 1'b1);
    end_sim();
  end
endmodule // tb_host_cmd_reg_eeprom_txbuf
